// ===== logic/ptt_pkg.sv
// Constants, types and tap tables shared by the prescaler and timer block
package ptt_pkg;

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int PSS_W = 11;
	localparam int PSW_W = 8;
	localparam int TMR_W = 8;
	localparam int MODE_W = 4;
	localparam int DIV_W = 3;
	localparam int TAP_W = 4;

	localparam logic [PSS_W-1:0] PSS_RESET = 11'h000;
	localparam logic [PSW_W-1:0] PSW_RESET = 8'h00;
	localparam logic [TMR_W-1:0] TMR_RESET = 8'h00;
	localparam logic [TMR_W-1:0] TMR_MAX = 8'hFF;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
	localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
	localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;

	// ****************************************************************
	// Mode register fields
	// ****************************************************************
	localparam int MODE_TB_BIT = 3;
	localparam int MODE_SEL_LSB = 1;
	localparam int MODE_CODE_HI = 2;
	localparam logic [2:0] MODE_PSW_CLR_CODE = 3'h7;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {OPM_ACTIVE, OPM_STANDBY, OPM_SUBACTIVE, OPM_WATCH, OPM_STOP} ptt_opmode_e;

	typedef struct packed {
		logic mode_wr;
		logic [MODE_W-1:0] mode_data;
		logic psw_clr;
		logic tb_clr;
		logic irq_clr;
	} ptt_sw_ctl_s;

	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic [DIV_W-1:0] div8;
		logic [TMR_W-1:0] timer;
		logic ovf;
		logic irq;
	} ptt_state_s;

	// ****************************************************************
	// Tap tables: number of low bits that must wrap
	// ****************************************************************
	function automatic logic [TAP_W-1:0] pss_tap_bits(input logic [2:0] code);
		case (code)
			3'h0: pss_tap_bits = 4'hB;
			3'h1: pss_tap_bits = 4'hA;
			3'h2: pss_tap_bits = 4'h9;
			3'h3: pss_tap_bits = 4'h7;
			3'h4: pss_tap_bits = 4'h5;
			3'h5: pss_tap_bits = 4'h3;
			3'h6: pss_tap_bits = 4'h2;
			default: pss_tap_bits = 4'h1;
		endcase
	endfunction : pss_tap_bits

	function automatic logic [TAP_W-1:0] psw_tap_bits(input logic [2:0] code);
		case (code)
			3'h0: psw_tap_bits = 4'h8;
			3'h1: psw_tap_bits = 4'h7;
			3'h2: psw_tap_bits = 4'h6;
			3'h3: psw_tap_bits = 4'h5;
			3'h4: psw_tap_bits = 4'h4;
			3'h5: psw_tap_bits = 4'h3;
			3'h6: psw_tap_bits = 4'h2;
			default: psw_tap_bits = 4'h1;
		endcase
	endfunction : psw_tap_bits

	// True when the low k bits are all ones, so the next advance wraps them
	function automatic logic low_bits_full(input logic [PSS_W-1:0] v, input logic [TAP_W-1:0] k);
		logic [PSS_W-1:0] mask;
		mask = PSS_W'((12'h001 << k) - 12'h001);
		low_bits_full = ((v & mask) == mask);
	endfunction : low_bits_full

endpackage : ptt_pkg

// ===== logic/ptt_prescaler.sv
// Free-running up-counter with halt and clear, used for both prescalers
`timescale 1ns/10ps
module ptt_prescaler #(
	parameter int W = 11
) (
	input clock,
	input rst_b,
	input advance,
	input halt,
	input clear,
	output logic [W-1:0] count
);

	typedef struct packed {
		logic [W-1:0] count;
	} ptt_cnt_state_s;

	ptt_cnt_state_s st_reg;
	ptt_cnt_state_s st_next;

	always_comb
	begin
		st_next = st_reg;
		if (clear)
			st_next.count = '0;
		else if (advance && !halt)
			st_next.count = W'(st_reg.count + 1'b1);
	end

	// Reset clears and holds the count
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign count = st_reg.count;

	a_cnt_halted: assert property (@(posedge clock) disable iff (!rst_b) // R3 R7
		(halt && !clear) |=> $stable(st_reg.count))
		else $error("Prescaler moved while halted");

endmodule : ptt_prescaler

// ===== logic/ptt_tap_select.sv
// Selects the timer input tap and emits one pulse per tap period
`timescale 1ns/10ps
module ptt_tap_select (
	input clock,
	input rst_b,
	input [ptt_pkg::PSS_W-1:0] sys_count,
	input sys_adv,
	input [ptt_pkg::PSW_W-1:0] sub_count,
	input sub_adv,
	input [ptt_pkg::MODE_W-1:0] mode,
	output logic tap_pulse
);

	typedef struct packed {
		logic pulse;
	} ptt_tap_state_s;

	ptt_tap_state_s st_reg;
	ptt_tap_state_s st_next;
	logic [2:0] code;

	always_comb
	begin
		code = mode[ptt_pkg::MODE_CODE_HI:0];
		st_next = st_reg;
		if (mode[ptt_pkg::MODE_TB_BIT])
			st_next.pulse = sub_adv && ptt_pkg::low_bits_full(ptt_pkg::PSS_W'(sub_count),
				ptt_pkg::psw_tap_bits(code)); // R14
		else
			st_next.pulse = sys_adv && ptt_pkg::low_bits_full(sys_count, ptt_pkg::pss_tap_bits(code)); // R16
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tap_pulse = st_reg.pulse;

	a_tap_needs_adv: assert property (@(posedge clock) disable iff (!rst_b) // R10
		tap_pulse |-> $past(sys_adv) || $past(sub_adv))
		else $error("Tap pulse without prescaler advance");

endmodule : ptt_tap_select

// ===== logic/ptt_timer.sv
// Top of the two prescalers and the free-running timer with time-base mode
// Function
// R1: System prescaler is 11-bit, mode-selected clock
// R2: Reset clears system prescaler, then it divides
// R3: System prescaler halts in stop, watch
// R4: Subactive mode feeds system prescaler subclock
// R5: Subclock prescaler counts oscillator divided by eight
// R6: Subclock prescaler cleared by reset or software
// R7: Subclock prescaler stops only reset, stop
// R8: Mode bits 3..1 all ones clear subclock prescaler
// R9: Prescaler taps feed other peripherals
// R10: Timer is 8-bit, clock chosen by mode
// R11: Timer resets to zero, increments per pulse
// R12: Wrap at maximum sets overflow and flag
// R13: Timer keeps counting, overflow every 256
// R14: Mode bit 3 selects subclock prescaler input
// R15: Time-base mode allows software clear both
// R16: Mode register 4-bit, reset zero, period table
// R17: Interrupt flag sticky until software clears
`timescale 1ns/10ps
module ptt_timer (
	input clock,
	input rst_b,
	input ptt_pkg::ptt_opmode_e op_mode,
	input sys_clk_tick,
	input sub_clk_tick,
	input sub_osc_tick,
	input ptt_pkg::ptt_sw_ctl_s sw_ctl,
	output logic [ptt_pkg::PSS_W-1:0] sys_prescaler,
	output logic [ptt_pkg::PSW_W-1:0] subclk_prescaler,
	output logic [ptt_pkg::TMR_W-1:0] timer_count,
	output logic timer_ovf,
	output logic timer_a_irq_flag
);

	// ****************************************************************
	// State and clock steering
	// ****************************************************************
	ptt_pkg::ptt_state_s st_reg;
	ptt_pkg::ptt_state_s st_next;
	logic pss_tick;
	logic pss_halt;
	logic pss_adv;
	logic psw_halt;
	logic psw_tick;
	logic psw_clr;
	logic psw_adv;
	logic tb_clear;
	logic tap_pulse;

	always_comb
	begin
		pss_tick = (op_mode == ptt_pkg::OPM_SUBACTIVE) ? sub_clk_tick : sys_clk_tick; // R1 R4
		pss_halt = (op_mode == ptt_pkg::OPM_STOP) || (op_mode == ptt_pkg::OPM_WATCH); // R3
		pss_adv = pss_tick && !pss_halt;
		psw_halt = (op_mode == ptt_pkg::OPM_STOP); // R7
		psw_tick = sub_osc_tick && (st_reg.div8 == ptt_pkg::DIV_LAST); // R5
		tb_clear = sw_ctl.tb_clr && st_reg.mode[ptt_pkg::MODE_TB_BIT]; // R15
		psw_clr = sw_ctl.psw_clr || tb_clear || (sw_ctl.mode_wr &&
			(sw_ctl.mode_data[ptt_pkg::MODE_TB_BIT:ptt_pkg::MODE_SEL_LSB] == ptt_pkg::MODE_PSW_CLR_CODE)); // R6 R8
		psw_adv = psw_tick && !psw_halt && !psw_clr;
	end

	// ****************************************************************
	// Prescalers and tap selection
	// ****************************************************************
	ptt_prescaler #(
		.W(ptt_pkg::PSS_W)
	) u_sys_prescaler (
		.clock(clock),
		.rst_b(rst_b),
		.advance(pss_tick),
		.halt(pss_halt),
		.clear(1'b0),
		.count(sys_prescaler)
	); // R1 R2 R9

	ptt_prescaler #(
		.W(ptt_pkg::PSW_W)
	) u_subclk_prescaler (
		.clock(clock),
		.rst_b(rst_b),
		.advance(psw_tick),
		.halt(psw_halt),
		.clear(psw_clr),
		.count(subclk_prescaler)
	); // R6 R7 R9

	ptt_tap_select u_tap (
		.clock(clock),
		.rst_b(rst_b),
		.sys_count(sys_prescaler),
		.sys_adv(pss_adv),
		.sub_count(subclk_prescaler),
		.sub_adv(psw_adv),
		.mode(st_reg.mode),
		.tap_pulse(tap_pulse)
	); // R10 R14

	// ****************************************************************
	// Mode register, divider, timer and flag
	// ****************************************************************
	always_comb
	begin
		st_next = st_reg;
		st_next.ovf = 1'b0;
		if (sw_ctl.mode_wr)
			st_next.mode = sw_ctl.mode_data; // R16
		if (sub_osc_tick && !psw_halt)
			st_next.div8 = ptt_pkg::DIV_W'(st_reg.div8 + 1'b1); // R5
		if (tb_clear)
			st_next.timer = ptt_pkg::TMR_RESET; // R15
		else if (tap_pulse)
		begin
			if (st_reg.timer == ptt_pkg::TMR_MAX)
			begin
				st_next.timer = ptt_pkg::TMR_RESET; // R12 R13
				st_next.ovf = 1'b1; // R12
			end
			else
				st_next.timer = ptt_pkg::TMR_W'(st_reg.timer + 1'b1); // R11
		end
		// Set beats a clear in the same cycle
		if (sw_ctl.irq_clr)
			st_next.irq = 1'b0;
		if (st_next.ovf)
			st_next.irq = 1'b1; // R12 R17
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			st_reg.mode <= ptt_pkg::MODE_RESET;
			st_reg.div8 <= ptt_pkg::DIV_RESET;
			st_reg.timer <= ptt_pkg::TMR_RESET;
			st_reg.ovf <= 1'b0;
			st_reg.irq <= 1'b0;
		end
		else
			st_reg <= st_next;
	end

	assign timer_count = st_reg.timer;
	assign timer_ovf = st_reg.ovf;
	assign timer_a_irq_flag = st_reg.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence seq_at_max_pulse;
		tap_pulse && (st_reg.timer == ptt_pkg::TMR_MAX) && !tb_clear;
	endsequence

	sequence seq_wrapped;
		(timer_count == ptt_pkg::TMR_RESET) && timer_ovf && timer_a_irq_flag;
	endsequence

	a_timer_wrap_ovf: assert property (seq_at_max_pulse |=> seq_wrapped) // R12
		else $error("Timer did not wrap with overflow");

	a_timer_step_one: assert property (tap_pulse && !tb_clear && (st_reg.timer != ptt_pkg::TMR_MAX) // R11
		|=> (timer_count == ptt_pkg::TMR_W'($past(st_reg.timer) + 1'b1)) && !timer_ovf)
		else $error("Timer did not step by one");

	a_timer_holds: assert property (!tap_pulse && !tb_clear |=> $stable(timer_count)) // R10
		else $error("Timer moved without input pulse");

	a_irq_sticky: assert property (timer_a_irq_flag && !sw_ctl.irq_clr |=> timer_a_irq_flag) // R17
		else $error("Interrupt flag dropped without clear");

	a_irq_set_wins: assert property (seq_at_max_pulse ##0 sw_ctl.irq_clr |=> timer_a_irq_flag) // R17
		else $error("Clear beat overflow set");

	a_pss_halted: assert property (pss_halt |=> $stable(sys_prescaler)) // R3
		else $error("System prescaler moved in stop or watch");

	a_pss_sub_src: assert property ((op_mode == ptt_pkg::OPM_SUBACTIVE) && sub_clk_tick // R4
		|=> sys_prescaler == ptt_pkg::PSS_W'($past(sys_prescaler) + 1'b1))
		else $error("Subactive prescaler not fed by subclock");

	a_psw_watch_runs: assert property ((op_mode == ptt_pkg::OPM_WATCH) && psw_tick && !psw_clr // R7
		|=> subclk_prescaler == ptt_pkg::PSW_W'($past(subclk_prescaler) + 1'b1))
		else $error("Subclock prescaler stopped in watch");

	a_psw_code_clear: assert property (sw_ctl.mode_wr // R8
		&& (sw_ctl.mode_data[ptt_pkg::MODE_TB_BIT:ptt_pkg::MODE_SEL_LSB] == ptt_pkg::MODE_PSW_CLR_CODE)
		|=> subclk_prescaler == ptt_pkg::PSW_RESET)
		else $error("Mode code did not clear subclock prescaler");

	a_tb_clear_both: assert property (tb_clear |=> (subclk_prescaler == ptt_pkg::PSW_RESET) // R15
		&& (timer_count == ptt_pkg::TMR_RESET))
		else $error("Time-base clear incomplete");

	a_reset_zero: assert property (@(posedge clock) disable iff (1'b0) // R2 R16
		!rst_b |=> (sys_prescaler == ptt_pkg::PSS_RESET) && (timer_count == ptt_pkg::TMR_RESET)
		&& (st_reg.mode == ptt_pkg::MODE_RESET) && !timer_a_irq_flag)
		else $error("Reset did not clear state");

	// ****************************************************************
	// Checks: overflow pulse and interrupt flag
	// ****************************************************************
	sequence seq_ovf_pulse;
		timer_ovf ##1 !timer_ovf;
	endsequence

	sequence seq_clear_no_set;
		sw_ctl.irq_clr && !(tap_pulse && (st_reg.timer == ptt_pkg::TMR_MAX) && !tb_clear);
	endsequence

	sequence seq_wrap_walk;
		seq_wrapped ##1 !timer_ovf;
	endsequence

	a_wrap_walk: assert property (seq_at_max_pulse |=> seq_wrap_walk) // R12 R13
		else $error("Wrap did not end in a single overflow pulse");

	a_ovf_one_cycle: assert property (timer_ovf |-> seq_ovf_pulse) // R12
		else $error("Overflow pulse lasted more than one cycle");

	a_ovf_after_max: assert property (timer_ovf |-> $past(tap_pulse) && !$past(tb_clear) // R12
		&& ($past(st_reg.timer) == ptt_pkg::TMR_MAX))
		else $error("Overflow without a pulse at the maximum count");

	a_irq_rise_ovf: assert property ($rose(timer_a_irq_flag) |-> timer_ovf) // R12
		else $error("Interrupt flag rose without overflow");

	a_irq_clears: assert property (seq_clear_no_set |=> !timer_a_irq_flag) // R17
		else $error("Interrupt flag not cleared by software");

	a_ovf_keeps_flag: assert property (timer_ovf |-> timer_a_irq_flag) // R12 R17
		else $error("Overflow left the flag clear");

	// ****************************************************************
	// Checks: timer clear and step
	// ****************************************************************
	sequence seq_refused_clear;
		sw_ctl.tb_clr && !st_reg.mode[ptt_pkg::MODE_TB_BIT] && !tap_pulse;
	endsequence

	a_tb_clr_refused: assert property (seq_refused_clear |=> $stable(timer_count)) // R15
		else $error("Time-base clear acted outside time-base mode");

	a_tb_clear_no_ovf: assert property (tb_clear |=> !timer_ovf) // R15
		else $error("Overflow raised during time-base clear");

	a_timer_moves_on_pulse: assert property ($changed(timer_count) |-> $past(tap_pulse) || $past(tb_clear)) // R11
		else $error("Timer changed without pulse or clear");

	// ****************************************************************
	// Checks: mode register and software clear of the subclock prescaler
	// ****************************************************************
	a_mode_written: assert property (sw_ctl.mode_wr |=> st_reg.mode == $past(sw_ctl.mode_data)) // R16
		else $error("Mode register did not take the written value");

	a_mode_kept: assert property (!sw_ctl.mode_wr |=> $stable(st_reg.mode)) // R16
		else $error("Mode register changed without a write");

	a_psw_sw_clear: assert property (sw_ctl.psw_clr |=> subclk_prescaler == ptt_pkg::PSW_RESET) // R6
		else $error("Software clear missed the subclock prescaler");

	// ****************************************************************
	// Checks: system prescaler clocking
	// ****************************************************************
	sequence seq_sys_step;
		((op_mode == ptt_pkg::OPM_ACTIVE) || (op_mode == ptt_pkg::OPM_STANDBY)) && sys_clk_tick;
	endsequence

	a_pss_sys_src: assert property (seq_sys_step // R1
		|=> sys_prescaler == ptt_pkg::PSS_W'($past(sys_prescaler) + 1'b1))
		else $error("System prescaler missed a system clock");

	a_pss_sub_only: assert property ((op_mode == ptt_pkg::OPM_SUBACTIVE) && !sub_clk_tick // R4
		|=> $stable(sys_prescaler))
		else $error("System clock reached prescaler in subactive");

	a_pss_idle: assert property (!sys_clk_tick && !sub_clk_tick |=> $stable(sys_prescaler)) // R1
		else $error("System prescaler moved without an input clock");

	// ****************************************************************
	// Checks: subclock divider and prescaler
	// ****************************************************************
	a_div8_step: assert property (sub_osc_tick && (op_mode != ptt_pkg::OPM_STOP) // R5
		|=> st_reg.div8 == ptt_pkg::DIV_W'($past(st_reg.div8) + 1'b1))
		else $error("Divide-by-eight missed an oscillator tick");

	a_div8_stop: assert property ((op_mode == ptt_pkg::OPM_STOP) |=> $stable(st_reg.div8)) // R7
		else $error("Divide-by-eight moved in stop mode");

	a_psw_between: assert property (sub_osc_tick && (st_reg.div8 != ptt_pkg::DIV_LAST) && !psw_clr // R5
		|=> $stable(subclk_prescaler))
		else $error("Subclock prescaler moved between divided ticks");

	a_psw_stop_holds: assert property ((op_mode == ptt_pkg::OPM_STOP) && !psw_clr // R7
		|=> $stable(subclk_prescaler))
		else $error("Subclock prescaler moved in stop mode");

	a_psw_runs: assert property (psw_tick && (op_mode != ptt_pkg::OPM_STOP) && !psw_clr // R5 R7
		|=> subclk_prescaler == ptt_pkg::PSW_W'($past(subclk_prescaler) + 1'b1))
		else $error("Subclock prescaler missed a divided tick");

endmodule : ptt_timer

// ===== testbench/ptt_timer_bench.sv
// Self-checking bench for the prescalers and the free-running timer
`timescale 1ns/10ps
module ptt_timer_bench;
	// ****************************************************************
	// Signals and bookkeeping
	// ****************************************************************
	typedef struct {int id; logic [10:0] v;} ptt_note_s;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	ptt_pkg::ptt_opmode_e op_mode = ptt_pkg::OPM_ACTIVE;
	logic sys_clk_tick = 1'b0;
	logic sub_clk_tick = 1'b0;
	logic sub_osc_tick = 1'b0;
	ptt_pkg::ptt_sw_ctl_s sw_ctl = '0;
	logic [ptt_pkg::PSS_W-1:0] sys_prescaler;
	logic [ptt_pkg::PSW_W-1:0] subclk_prescaler;
	logic [ptt_pkg::TMR_W-1:0] timer_count;
	logic timer_ovf;
	logic timer_a_irq_flag;
	int err_count = 0;
	int n_compared = 0;
	int n_ovf = 0;
	logic [31:0] seed = 32'd85779;
	logic [10:0] sys_m = 11'h000;
	logic [7:0] psw_m = 8'h00;
	logic [7:0] tmr_m = 8'h00;
	ptt_note_s notes[$];
	int per[8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};

	always #25 clock = ~clock;

	ptt_timer dut (.clock(clock), .rst_b(rst_b), .op_mode(op_mode), .sys_clk_tick(sys_clk_tick),
		.sub_clk_tick(sub_clk_tick), .sub_osc_tick(sub_osc_tick), .sw_ctl(sw_ctl),
		.sys_prescaler(sys_prescaler), .subclk_prescaler(subclk_prescaler), .timer_count(timer_count),
		.timer_ovf(timer_ovf), .timer_a_irq_flag(timer_a_irq_flag));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic int xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		xs = int'(seed & 32'h7FFF_FFFF);
	endfunction : xs

	task automatic cyc();
		@(posedge clock);
		#2;
	endtask : cyc

	task automatic ticks(input int which, input int n);
		if (which == 0) sys_clk_tick = 1'b1;
		if (which == 1) sub_clk_tick = 1'b1;
		if (which == 2) sub_osc_tick = 1'b1;
		repeat (n) cyc();
		sys_clk_tick = 1'b0;
		sub_clk_tick = 1'b0;
		sub_osc_tick = 1'b0;
	endtask : ticks

	task automatic sw(input logic [7:0] v);
		sw_ctl = ptt_pkg::ptt_sw_ctl_s'(v);
		cyc();
		sw_ctl = '0;
	endtask : sw

	// Let the tap pipeline settle, then leave a note for the monitor
	task automatic expect_val(input int id, input logic [10:0] v);
		ptt_note_s n;
		repeat (3) cyc();
		n.id = id;
		n.v = v;
		notes.push_back(n);
	endtask : expect_val

	task automatic chk(input logic [10:0] a, input logic [10:0] e);
		n_compared++;
		if (a !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask : chk

	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// ****************************************************************
	// Monitor
	// ****************************************************************
	always @(negedge clock)
	begin : mon
		ptt_note_s n;
		logic [10:0] act;
		if (rst_b === 1'b1 && timer_ovf === 1'b1)
		begin
			n_ovf++;
			chk({3'h0, timer_count}, 11'h000);
			chk({10'h000, timer_a_irq_flag}, 11'h001);
		end
		if (notes.size() > 0)
		begin
			n = notes.pop_front();
			case (n.id)
				0: act = sys_prescaler;
				1: act = {3'h0, subclk_prescaler};
				2: act = {3'h0, timer_count};
				3: act = {10'h000, timer_a_irq_flag};
				default: act = 11'(n_ovf);
			endcase
			chk(act, n.v);
		end
	end

	initial
	begin
		#(50 * 40000);
		err_count++;
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin : main
		int n;
		repeat (16) cyc();
		rst_b = 1'b1;
		expect_val(0, 11'h000);
		expect_val(1, 11'h000);
		expect_val(2, 11'h000);
		expect_val(3, 11'h000);
		for (int m = 0; m < 5; m++)
		begin
			op_mode = ptt_pkg::ptt_opmode_e'(m);
			n = 1 + xs() % 40;
			ticks(0, n);
			ticks(1, n + 3);
			if (m < 2) sys_m = sys_m + 11'(n);
			if (m == 2) sys_m = sys_m + 11'(n + 3);
			expect_val(0, sys_m);
			ticks(2, 8 * n);
			if (m != 4) psw_m = psw_m + 8'(n);
			expect_val(1, {3'h0, psw_m});
		end
		op_mode = ptt_pkg::OPM_ACTIVE;
		sw(8'h04);
		expect_val(1, 11'h000);
		ticks(2, 24);
		sw({1'b1, 4'hE, 3'h0});
		expect_val(1, 11'h000);
		ticks(2, 80);
		expect_val(1, 11'h00A);
		expect_val(2, 11'h002);
		sw(8'h02);
		expect_val(1, 11'h000);
		expect_val(2, 11'h000);
		for (int c = 0; c < 8; c++)
		begin
			sw({1'b1, 1'b0, 3'(c), 3'h0});
			ticks(0, per[c]);
			tmr_m = tmr_m + 8'h01;
			expect_val(2, {3'h0, tmr_m});
		end
		sw(8'h02);
		expect_val(2, {3'h0, tmr_m});
		ticks(0, 2 * (256 - int'(tmr_m)));
		expect_val(2, 11'h000);
		expect_val(4, 11'h001);
		ticks(0, 512);
		expect_val(4, 11'h002);
		expect_val(3, 11'h001);
		sw(8'h01);
		expect_val(3, 11'h000);
		// Clear held across an overflow: the set must win on that edge
		sw_ctl.irq_clr = 1'b1;
		ticks(0, 512);
		repeat (3) cyc();
		sw_ctl.irq_clr = 1'b0;
		expect_val(4, 11'h003);
		expect_val(3, 11'h000);
		repeat (4) cyc();
		wrap_up();
	end
endmodule : ptt_timer_bench
